// File: hdl/smst_engine.sv
// Static memory strobe timing engine: setup/pulse/hold waveforms per chip select.
// Assumes a host that holds a request until ack and keeps timings stable in use.
// Summary of operation
// - Read by chip select: capture data on the edge raising chip select.
// - Write strobe falls after setup, low for pulse, then hold.
// - Byte-write strobes of enabled byte lanes copy the write strobe waveform exactly; the other lanes stay high.
// - Write chip select has its own setup and pulse from address valid.
// - One write cycle length bounds both signals; address changes at cycle end.
// - All timings held per chip select, counted in whole clock cycles.
// - Zero setup keeps signal asserted across back-to-back writes to same memory.
// - Strobe-controlled write drives data from strobe setup to cycle end.
// - Chip-select-controlled write drives data from chip select setup to end.
// - Setup field 6 bits: 128 times bit 5 plus bits 4..0.
// - Pulse field 7 bits: 256 times bit 6 plus bits 5..0.
// - Cycle field 9 bits: 256 times bits 8..7 plus bits 6..0.
// - Zero strobe hold: a back-to-back access changes address and byte selects on the same edge the strobe rises.
// - One idle cycle between transfers on different chip selects.
// - During that idle cycle all selects and strobes are high.
// - Read by read strobe: capture data on edge raising read strobe.
// - Read strobe falls after setup, low for pulse, then hold.
// - One read cycle length applies to read strobe and read chip select.
// - Byte selects change with the same timing as the address.
`timescale 1ns/1ps
module smst_engine (
   input wire logic clk,
   input wire logic rst,
   input wire logic req,
   input wire logic req_write,
   input wire logic [smst_pkg::CS_IDX_W-1:0] req_cs,
   input wire logic [smst_pkg::ADDR_W-1:0] req_addr,
   input wire logic [smst_pkg::DATA_W-1:0] req_wdata,
   input wire logic [smst_pkg::NUM_BYTES-1:0] req_byte_en,
   output logic ack,
   output logic [smst_pkg::DATA_W-1:0] rdata,
   output logic rdata_valid,
   input wire logic [smst_pkg::NUM_CS*smst_pkg::SETUP_W-1:0] wr_strobe_setup,
   input wire logic [smst_pkg::NUM_CS*smst_pkg::PULSE_W-1:0] wr_strobe_pulse,
   input wire logic [smst_pkg::NUM_CS*smst_pkg::SETUP_W-1:0] cs_write_setup,
   input wire logic [smst_pkg::NUM_CS*smst_pkg::PULSE_W-1:0] cs_write_pulse,
   input wire logic [smst_pkg::NUM_CS*smst_pkg::CYCLE_W-1:0] write_cycle_len,
   input wire logic [smst_pkg::NUM_CS*smst_pkg::SETUP_W-1:0] rd_strobe_setup,
   input wire logic [smst_pkg::NUM_CS*smst_pkg::PULSE_W-1:0] rd_strobe_pulse,
   input wire logic [smst_pkg::NUM_CS*smst_pkg::SETUP_W-1:0] cs_read_setup,
   input wire logic [smst_pkg::NUM_CS*smst_pkg::PULSE_W-1:0] cs_read_pulse,
   input wire logic [smst_pkg::NUM_CS*smst_pkg::CYCLE_W-1:0] read_cycle_len,
   input wire logic [smst_pkg::NUM_CS-1:0] read_mode,
   input wire logic [smst_pkg::NUM_CS-1:0] write_mode,
   input wire logic [smst_pkg::NUM_CS-1:0] byte_write_mode,
   output logic [smst_pkg::ADDR_W-1:0] mem_addr,
   output logic [smst_pkg::DATA_W-1:0] mem_dout,
   output logic mem_dout_en,
   input wire logic [smst_pkg::DATA_W-1:0] mem_din,
   output logic [smst_pkg::NUM_CS-1:0] chip_sel_n,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic [smst_pkg::NUM_BYTES-1:0] byte_wr_strobe_n,
   output logic [smst_pkg::NUM_BYTES-1:0] byte_lane_sel_n
);
   smst_pkg::smst_state_e state;
   smst_pkg::smst_state_e next_state;
   logic [smst_pkg::CNT_W-1:0] count;
   logic [smst_pkg::CNT_W-1:0] next_count;
   logic [smst_pkg::CS_IDX_W-1:0] cur_cs;
   logic [smst_pkg::CS_IDX_W-1:0] last_cs;
   logic cur_write;
   logic [smst_pkg::NUM_BYTES-1:0] cur_be;
   logic [smst_pkg::ADDR_W-1:0] cur_addr;
   logic [smst_pkg::DATA_W-1:0] cur_wdata;

   // Per chip select field selection
   logic [smst_pkg::CNT_W-1:0] ws_setup, ws_pulse, cw_setup, cw_pulse, w_cycle;
   logic [smst_pkg::CNT_W-1:0] rs_setup, rs_pulse, cr_setup, cr_pulse, r_cycle;
   assign ws_setup = smst_pkg::smst_setup_cycles(wr_strobe_setup[cur_cs*smst_pkg::SETUP_W +: smst_pkg::SETUP_W]);
   assign cw_setup = smst_pkg::smst_setup_cycles(cs_write_setup[cur_cs*smst_pkg::SETUP_W +: smst_pkg::SETUP_W]);
   assign rs_setup = smst_pkg::smst_setup_cycles(rd_strobe_setup[cur_cs*smst_pkg::SETUP_W +: smst_pkg::SETUP_W]);
   assign cr_setup = smst_pkg::smst_setup_cycles(cs_read_setup[cur_cs*smst_pkg::SETUP_W +: smst_pkg::SETUP_W]);
   assign ws_pulse = smst_pkg::smst_pulse_cycles(wr_strobe_pulse[cur_cs*smst_pkg::PULSE_W +: smst_pkg::PULSE_W]);
   assign cw_pulse = smst_pkg::smst_pulse_cycles(cs_write_pulse[cur_cs*smst_pkg::PULSE_W +: smst_pkg::PULSE_W]);
   assign rs_pulse = smst_pkg::smst_pulse_cycles(rd_strobe_pulse[cur_cs*smst_pkg::PULSE_W +: smst_pkg::PULSE_W]);
   assign cr_pulse = smst_pkg::smst_pulse_cycles(cs_read_pulse[cur_cs*smst_pkg::PULSE_W +: smst_pkg::PULSE_W]);
   assign w_cycle = smst_pkg::smst_cycle_cycles(write_cycle_len[cur_cs*smst_pkg::CYCLE_W +: smst_pkg::CYCLE_W]);
   assign r_cycle = smst_pkg::smst_cycle_cycles(read_cycle_len[cur_cs*smst_pkg::CYCLE_W +: smst_pkg::CYCLE_W]);

   logic in_access;
   logic [smst_pkg::CNT_W-1:0] strobe_setup, strobe_pulse, cs_setup, cs_pulse, cyc_len;
   assign in_access = (state == smst_pkg::SMST_ACCESS);
   assign strobe_setup = cur_write ? ws_setup : rs_setup;
   assign strobe_pulse = cur_write ? ws_pulse : rs_pulse;
   assign cs_setup = cur_write ? cw_setup : cr_setup;
   assign cs_pulse = cur_write ? cw_pulse : cr_pulse;
   assign cyc_len = cur_write ? w_cycle : r_cycle;

   logic strobe_on, strobe_fall, strobe_rise, cs_on, cs_fall, cs_rise;
   smst_wave u_strobe_wave (
      .count(count),
      .active(in_access),
      .setup(strobe_setup),
      .pulse(strobe_pulse),
      .on(strobe_on),
      .fall(strobe_fall),
      .rise(strobe_rise)
   );
   smst_wave u_cs_wave (
      .count(count),
      .active(in_access),
      .setup(cs_setup),
      .pulse(cs_pulse),
      .on(cs_on),
      .fall(cs_fall),
      .rise(cs_rise)
   );

   // Access ends on the last counted cycle; a zero cycle still takes one
   logic last_cycle;
   logic accept;
   logic need_gap;
   assign last_cycle = in_access && ((count + smst_pkg::CNT_ONE) >= cyc_len);
   assign accept = req && !rst && ((state == smst_pkg::SMST_IDLE) || last_cycle);
   assign need_gap = (last_cs != smst_pkg::CS_NONE) && (req_cs != last_cs);
   assign ack = accept;

   always_comb begin
      next_state = state;
      next_count = count + smst_pkg::CNT_ONE;
      case (state)
         smst_pkg::SMST_IDLE: begin
            next_count = smst_pkg::CNT_ZERO;
            if (req) begin
               next_state = need_gap ? smst_pkg::SMST_GAP : smst_pkg::SMST_ACCESS;
            end
         end
         smst_pkg::SMST_GAP: begin
            next_state = smst_pkg::SMST_ACCESS;
            next_count = smst_pkg::CNT_ZERO;
         end
         smst_pkg::SMST_ACCESS: begin
            if (last_cycle) begin
               next_count = smst_pkg::CNT_ZERO;
               if (!req) begin
                  next_state = smst_pkg::SMST_IDLE;
               end else if (need_gap) begin
                  next_state = smst_pkg::SMST_GAP;
               end
            end
         end
         default: begin
            next_state = smst_pkg::SMST_IDLE;
            next_count = smst_pkg::CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= smst_pkg::SMST_IDLE;
         count <= smst_pkg::CNT_ZERO;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   // Access context; address and byte selects change only when a new access is taken
   always_ff @(posedge clk) begin
      if (rst) begin
         cur_cs <= smst_pkg::CS_NONE;
         last_cs <= smst_pkg::CS_NONE;
         cur_write <= 1'b0;
         cur_be <= '0;
         cur_addr <= '0;
         cur_wdata <= '0;
      end else if (accept) begin
         cur_cs <= req_cs;
         last_cs <= req_cs;
         cur_write <= req_write;
         cur_be <= req_byte_en;
         cur_addr <= req_addr;
         cur_wdata <= req_wdata;
      end
   end

   // Address and data launch with the count-zero outputs, so setup counts from them
   logic launch;
   assign launch = in_access && (count == smst_pkg::CNT_ZERO);
   always_ff @(posedge clk) begin
      if (rst) begin
         mem_addr <= '0;
         mem_dout <= '0;
      end else if (launch) begin
         mem_addr <= cur_addr;
         mem_dout <= cur_wdata;
      end
   end

   // Strobes registered; a zero setup start meets the previous access without a gap
   logic [smst_pkg::NUM_CS-1:0] cs_onehot;
   logic bw_mode, next_dout_en;
   assign bw_mode = byte_write_mode[cur_cs] == smst_pkg::BAT_BYTE_WRITE;
   assign cs_onehot = (cs_on && cur_cs < smst_pkg::CS_IDX_W'(smst_pkg::NUM_CS)) ?
      smst_pkg::NUM_CS'(1) << cur_cs : '0;
   assign next_dout_en = in_access && cur_write && (write_mode[cur_cs] == smst_pkg::WRITE_BY_STROBE ?
      count >= ws_setup : count >= cw_setup);

   always_ff @(posedge clk) begin
      if (rst || !in_access) begin
         chip_sel_n <= '1;
         read_strobe_n <= 1'b1;
         write_strobe_n <= 1'b1;
         byte_wr_strobe_n <= '1;
         mem_dout_en <= 1'b0;
      end else begin
         chip_sel_n <= ~cs_onehot;
         read_strobe_n <= !(strobe_on && !cur_write);
         write_strobe_n <= !(strobe_on && cur_write && !bw_mode);
         byte_wr_strobe_n <= ~({smst_pkg::NUM_BYTES{strobe_on && cur_write && bw_mode}} & cur_be);
         mem_dout_en <= next_dout_en;
      end
   end

   // Byte selects follow the address; all high in the idle gap and in byte-write mode
   always_ff @(posedge clk) begin
      if (rst || state == smst_pkg::SMST_GAP) begin
         byte_lane_sel_n <= '1;
      end else if (launch) begin
         byte_lane_sel_n <= bw_mode ? '1 : ~cur_be;
      end
   end

   // Data captured on the edge that raises the controlling signal
   // Zero hold: that edge closes the cycle, one past the last count
   logic capture, rd_by_cs, late_capture, pend_capture;
   logic [smst_pkg::CNT_W-1:0] rd_ctrl_end;
   assign rd_by_cs = read_mode[cur_cs] == smst_pkg::READ_BY_CS;
   assign rd_ctrl_end = rd_by_cs ? cs_setup + cs_pulse : strobe_setup + strobe_pulse;
   assign late_capture = in_access && !cur_write && last_cycle && (rd_ctrl_end >= cyc_len);
   assign capture = (in_access && !cur_write && (rd_by_cs ? cs_rise : strobe_rise)) || pend_capture;
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= '0;
         rdata_valid <= 1'b0;
         pend_capture <= 1'b0;
      end else begin
         rdata_valid <= capture;
         pend_capture <= late_capture;
         if (capture) begin
            rdata <= mem_din;
         end
      end
   end

   a_gap_all_high: assert property (@(posedge clk) disable iff (rst)
      $past(state) == smst_pkg::SMST_GAP |-> &chip_sel_n && read_strobe_n && &byte_lane_sel_n
      && &byte_wr_strobe_n) else $error("Select active after idle gap");
   a_gap_on_switch: assert property (@(posedge clk) disable iff (rst)
      in_access && last_cycle && req && need_gap |=> state == smst_pkg::SMST_GAP)
      else $error("No idle cycle on chip select change");
   a_wr_strobe_fall: assert property (@(posedge clk) disable iff (rst)
      in_access && cur_write && !bw_mode && strobe_fall && strobe_pulse != smst_pkg::CNT_ZERO
      |=> !write_strobe_n) else $error("Write strobe late");
   a_wr_strobe_rise: assert property (@(posedge clk) disable iff (rst)
      in_access && cur_write && strobe_rise && !last_cycle |=> write_strobe_n && &byte_wr_strobe_n)
      else $error("Write strobe not raised");
   a_byte_wr_copy: assert property (@(posedge clk) disable iff (rst)
      bw_mode |-> write_strobe_n) else $error("Single strobe used in byte-write mode");
   a_rd_capture: assert property (@(posedge clk) disable iff (rst)
      capture |=> rdata_valid && rdata == $past(mem_din)) else $error("Read data not captured");
   a_addr_stable: assert property (@(posedge clk) disable iff (rst)
      !(in_access && count == smst_pkg::CNT_ZERO) |=> $stable(mem_addr))
      else $error("Address moved mid access");
   a_dout_end: assert property (@(posedge clk) disable iff (rst)
      !in_access |=> !mem_dout_en) else $error("Data driven outside access");
   a_rd_strobe_fall: assert property (@(posedge clk) disable iff (rst)
      in_access && !cur_write && strobe_fall && !strobe_rise |=> !read_strobe_n)
      else $error("Read strobe late");
   c_write: cover property (@(posedge clk) in_access && cur_write && last_cycle);
   c_read: cover property (@(posedge clk) capture);
   c_gap: cover property (@(posedge clk) state == smst_pkg::SMST_GAP);
   c_b2b: cover property (@(posedge clk) last_cycle && accept && !need_gap);
endmodule : smst_engine

// File: common/smst_pkg.sv
// Constants for the static memory strobe timing generator.
// Shared by the top-level timing engine and its per-signal waveform unit.
package smst_pkg;
   localparam int NUM_CS = 6;
   localparam int NUM_BYTES = 4;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 32;
   localparam int SETUP_W = 6;
   localparam int PULSE_W = 7;
   localparam int CYCLE_W = 9;
   localparam int CNT_W = 10;
   localparam int CS_IDX_W = 3;
   localparam logic [CNT_W-1:0] SETUP_HI_WEIGHT = 10'h0_080;
   localparam logic [CNT_W-1:0] PULSE_HI_WEIGHT = 10'h0_100;
   localparam logic [CNT_W-1:0] CYCLE_HI_WEIGHT = 10'h0_100;
   localparam logic [CNT_W-1:0] CNT_ONE = 10'h0_001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 10'h0_000;
   localparam logic [CS_IDX_W-1:0] CS_NONE = 3'h7;
   localparam logic READ_BY_CS = 1'h0;
   localparam logic WRITE_BY_STROBE = 1'h1;
   localparam logic WRITE_BY_CS = 1'h0;
   localparam logic BAT_BYTE_WRITE = 1'h1;

   typedef enum logic [1:0] {
      SMST_IDLE = 2'b00,
      SMST_GAP = 2'b01,
      SMST_ACCESS = 2'b10
   } smst_state_e;

   // Setup decode: 128 x bit 5 plus bits 4..0
   function automatic logic [CNT_W-1:0] smst_setup_cycles(input logic [SETUP_W-1:0] f);
      smst_setup_cycles = (f[5] ? SETUP_HI_WEIGHT : CNT_ZERO) + {5'h00, f[4:0]};
   endfunction : smst_setup_cycles

   // Pulse decode: 256 x bit 6 plus bits 5..0
   function automatic logic [CNT_W-1:0] smst_pulse_cycles(input logic [PULSE_W-1:0] f);
      smst_pulse_cycles = (f[6] ? PULSE_HI_WEIGHT : CNT_ZERO) + {4'h0, f[5:0]};
   endfunction : smst_pulse_cycles

   // Cycle decode: 256 x bits 8..7 plus bits 6..0
   function automatic logic [CNT_W-1:0] smst_cycle_cycles(input logic [CYCLE_W-1:0] f);
      logic [CNT_W-1:0] hi;
      hi = CNT_ZERO;
      if (f[7]) begin
         hi = hi + CYCLE_HI_WEIGHT;
      end
      if (f[8]) begin
         hi = hi + (CYCLE_HI_WEIGHT << 1);
      end
      smst_cycle_cycles = hi + {3'h0, f[6:0]};
   endfunction : smst_cycle_cycles
endpackage : smst_pkg

// File: hdl/smst_wave.sv
// One strobe waveform: active between setup and setup plus pulse.
// Assumes the access counter starts at zero on the cycle the address is set.
`timescale 1ns/1ps
module smst_wave (
   input wire logic [smst_pkg::CNT_W-1:0] count,
   input wire logic active,
   input wire logic [smst_pkg::CNT_W-1:0] setup,
   input wire logic [smst_pkg::CNT_W-1:0] pulse,
   output logic on,
   output logic fall,
   output logic rise
);
   logic [smst_pkg::CNT_W-1:0] end_cnt;
   assign end_cnt = setup + pulse;
   assign on = active && (count >= setup) && (count < end_cnt);
   assign fall = active && (count == setup);
   assign rise = active && (count == end_cnt);
endmodule : smst_wave

// File: sim/smst_mem_model.sv
// Far-side model: async SRAM on the low chip selects, LCD-style device on LCD_CS and above.
// Assumes registered active-low controls from the engine, sampled on the falling clock edge.
`timescale 1ns/1ps
module smst_mem_model #(parameter int LCD_CS = 4) (
   input wire logic clk,
   input wire logic [5:0] chip_sel_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [3:0] byte_wr_strobe_n,
   input wire logic [23:0] mem_addr,
   input wire logic [31:0] mem_dout,
   input wire logic mem_dout_en,
   output logic [31:0] mem_din
);
   logic [31:0] mem [16];
   logic [31:0] last = 32'h0000_0000;
   logic wr_prev = 1'b1;
   logic sel_prev = 1'b0;
   logic en_prev = 1'b0;
   logic [3:0] a_prev = 4'h0;
   logic [31:0] d_prev = 32'h0000_0000;
   wire wr_hi = write_strobe_n & (&byte_wr_strobe_n);
   // SRAM needs its read strobe, LCD only its chip select
   wire rd_on = (!(&chip_sel_n[LCD_CS-1:0]) && !read_strobe_n) || !(&chip_sel_n[5:LCD_CS]);
   // Released bus shows the inverse of the last word
   assign mem_din = rd_on ? mem[mem_addr[3:0]] : ~last;
   always @(negedge clk) begin
      if (rd_on) last <= mem[mem_addr[3:0]];
      // Latch on strobe rise; undriven data lands corrupted
      if (!wr_prev && wr_hi && sel_prev) mem[a_prev] <= en_prev ? d_prev : ~d_prev;
      wr_prev <= wr_hi;
      sel_prev <= !(&chip_sel_n);
      en_prev <= mem_dout_en;
      a_prev <= mem_addr[3:0];
      d_prev <= mem_dout;
   end
endmodule : smst_mem_model

// File: sim/test_static_mem_strobe_timing.sv
// Self-checking bench for the strobe timing engine with a far-side memory model.
// Assumes the engine acks a held request and lags its counter by one register stage.
`timescale 1ns/1ps
module test_static_mem_strobe_timing;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req = 1'b0;
   logic req_write = 1'b0;
   logic [2:0] req_cs = 3'h0;
   logic [23:0] req_addr = 24'h00_0000;
   logic [31:0] req_wdata = 32'h0000_0000;
   logic [3:0] req_byte_en = 4'hf;
   logic [35:0] wr_strobe_setup = '0, cs_write_setup = '0, rd_strobe_setup = '0, cs_read_setup = '0;
   logic [41:0] wr_strobe_pulse = '0, cs_write_pulse = '0, rd_strobe_pulse = '0, cs_read_pulse = '0;
   logic [53:0] write_cycle_len = '0, read_cycle_len = '0;
   logic [5:0] read_mode = '0, write_mode = '0, byte_write_mode = '0;
   wire ack, rdata_valid, mem_dout_en, read_strobe_n, write_strobe_n;
   wire [31:0] rdata, mem_dout, mem_din;
   wire [23:0] mem_addr;
   wire [5:0] chip_sel_n;
   wire [3:0] byte_wr_strobe_n, byte_lane_sel_n;
   int bad_count = 0, checks = 0, t = 0, ack_t = 0, prev_ack_t = 0, nentry = 0, mcs = 0;
   int fall_t [5], rise_t [5], nrise [5];
   logic [4:0] ps = 5'h1f;
   logic ah_prev = 1'b1;
   logic [3:0] gap_lanes = 4'h0;

   smst_engine smst_engine_inst (.*);
   smst_mem_model #(.LCD_CS(4)) smst_mem_model_inst (.*);

   always #2 clk = ~clk;

   // Edge times of strobe, watched chip select, read strobe, byte strobe 3, data drive
   always @(negedge clk) begin
      logic [4:0] s;
      logic ah;
      s = {~mem_dout_en, byte_wr_strobe_n[3], read_strobe_n, chip_sel_n[mcs], write_strobe_n};
      ah = (&chip_sel_n) & read_strobe_n & write_strobe_n & (&byte_wr_strobe_n);
      t++;
      if (ack === 1'b1) begin
         prev_ack_t = ack_t;
         ack_t = t;
      end
      for (int i = 0; i < 5; i++) begin
         if (ps[i] && !s[i]) fall_t[i] = t;
         if (!ps[i] && s[i]) begin
            rise_t[i] = t;
            nrise[i]++;
         end
      end
      if (ah && !ah_prev) begin
         if (nentry == 0) gap_lanes = byte_lane_sel_n;
         nentry++;
      end
      ps = s;
      ah_prev = ah;
   end

   task automatic chk_num(input int got, input int exp);
      checks++;
      if (got != exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: cycles %0d, expected %0d", $time, got, exp);
      end
   endtask : chk_num

   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask : chk_data

   task automatic cfg(input int c, input logic [5:0] ws, input logic [6:0] wp, input logic [5:0] cws,
      input logic [6:0] cwp, input logic [8:0] wc, input logic [5:0] rs, input logic [6:0] rp,
      input logic [5:0] crs, input logic [6:0] crp, input logic [8:0] rc, input logic [2:0] m);
      wr_strobe_setup[c*6 +: 6] <= ws;
      wr_strobe_pulse[c*7 +: 7] <= wp;
      cs_write_setup[c*6 +: 6] <= cws;
      cs_write_pulse[c*7 +: 7] <= cwp;
      write_cycle_len[c*9 +: 9] <= wc;
      rd_strobe_setup[c*6 +: 6] <= rs;
      rd_strobe_pulse[c*7 +: 7] <= rp;
      cs_read_setup[c*6 +: 6] <= crs;
      cs_read_pulse[c*7 +: 7] <= crp;
      read_cycle_len[c*9 +: 9] <= rc;
      read_mode[c] <= m[2];
      write_mode[c] <= m[1];
      byte_write_mode[c] <= m[0];
   endtask : cfg

   // Holds the request until ack, returns on the taking edge
   task automatic issue(input logic w, input int c, input logic [23:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      req <= 1'b1;
      req_write <= w;
      req_cs <= 3'(c);
      req_addr <= a;
      req_wdata <= d;
      req_byte_en <= be;
      do begin
         @(negedge clk);
         n++;
      end while (ack !== 1'b1 && n < 2000);
      @(posedge clk);
   endtask : issue

   task automatic quiet(input int n);
      req <= 1'b0;
      repeat (n) @(posedge clk);
   endtask : quiet

   task automatic rd(input int c, input logic [23:0] a, input logic [31:0] exp);
      int n;
      n = 0;
      issue(1'b0, c, a, 32'h0000_0000, 4'hf);
      req <= 1'b0;
      do begin
         @(negedge clk);
         n++;
      end while (rdata_valid !== 1'b1 && n < 100);
      chk_data(32'(rdata_valid), 32'h0000_0001);
      chk_data(rdata, exp);
      repeat (10) @(posedge clk);
   endtask : rd

   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test

   initial begin
      #100000;
      bad_count++;
      end_of_test();
   end

   initial begin
      @(posedge clk);
      cfg(0, 6'h01, 7'h02, 6'h00, 7'h04, 9'h004, 6'h01, 7'h02, 6'h00, 7'h04, 9'h004, 3'h6);
      cfg(1, 6'h01, 7'h02, 6'h02, 7'h02, 9'h005, 6'h01, 7'h02, 6'h00, 7'h04, 9'h004, 3'h4);
      cfg(2, 6'h00, 7'h03, 6'h00, 7'h03, 9'h003, 6'h01, 7'h02, 6'h00, 7'h04, 9'h004, 3'h6);
      cfg(3, 6'h21, 7'h41, 6'h02, 7'h7f, 9'h183, 6'h01, 7'h02, 6'h00, 7'h04, 9'h004, 3'h6);
      cfg(4, 6'h01, 7'h02, 6'h00, 7'h04, 9'h004, 6'h00, 7'h01, 6'h01, 7'h02, 9'h004, 3'h2);
      cfg(5, 6'h01, 7'h02, 6'h00, 7'h04, 9'h004, 6'h01, 7'h02, 6'h00, 7'h04, 9'h004, 3'h7);
      @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk_data(32'(chip_sel_n), 32'h0000_003f);
      chk_data(32'(mem_dout_en), 32'h0000_0000);
      @(posedge clk);
      issue(1'b1, 0, 24'h00_0001, 32'ha5a5_0001, 4'h5);
      quiet(10);
      chk_num(fall_t[0] - ack_t, 3);
      chk_num(rise_t[0] - fall_t[0], 2);
      chk_num(fall_t[1] - ack_t, 2);
      chk_num(rise_t[1] - fall_t[1], 4);
      chk_num(fall_t[4] - ack_t, 3);
      chk_num(rise_t[4] - ack_t, 6);
      chk_data(32'(byte_lane_sel_n), 32'h0000_000a);
      chk_data(32'(mem_addr), 32'h0000_0001);
      rd(0, 24'h00_0001, 32'ha5a5_0001);
      chk_num(fall_t[2] - ack_t, 3);
      chk_num(rise_t[2] - fall_t[2], 2);
      mcs = 1;
      issue(1'b1, 1, 24'h00_0002, 32'h5a5a_0002, 4'hf);
      quiet(10);
      // Chip select change: the idle gap adds one cycle
      chk_num(fall_t[4] - ack_t, 5);
      chk_num(rise_t[4] - ack_t, 8);
      chk_num(fall_t[1] - ack_t, 5);
      rd(1, 24'h00_0002, 32'h5a5a_0002);
      issue(1'b1, 4, 24'h00_0004, 32'hc3c3_0004, 4'hf);
      quiet(10);
      rd(4, 24'h00_0004, 32'hc3c3_0004);
      mcs = 5;
      issue(1'b1, 5, 24'h00_0005, 32'h3c3c_0005, 4'hf);
      quiet(10);
      chk_num(fall_t[3] - ack_t, 4);
      chk_num(rise_t[3] - fall_t[3], 2);
      rd(5, 24'h00_0005, 32'h3c3c_0005);
      mcs = 3;
      issue(1'b1, 3, 24'h00_0003, 32'h1111_0003, 4'hf);
      issue(1'b1, 3, 24'h00_0003, 32'h2222_0003, 4'hf);
      quiet(800);
      chk_num(ack_t - prev_ack_t, 772);
      chk_num(fall_t[0] - ack_t, 131);
      chk_num(rise_t[0] - fall_t[0], 257);
      chk_num(fall_t[1] - ack_t, 4);
      chk_num(rise_t[1] - fall_t[1], 319);
      mcs = 2;
      nrise[0] = 0;
      nrise[1] = 0;
      for (int k = 0; k < 3; k++) issue(1'b1, 2, 24'h00_0006, 32'h0000_0006, 4'hf);
      quiet(10);
      chk_num(nrise[0], 1);
      chk_num(nrise[1], 1);
      mcs = 0;
      nentry = 0;
      issue(1'b1, 0, 24'h00_0007, 32'h0000_0007, 4'hf);
      issue(1'b1, 2, 24'h00_0008, 32'h0000_0008, 4'hf);
      quiet(10);
      chk_num(ack_t - prev_ack_t, 5);
      chk_num(nentry, 2);
      chk_data(32'(gap_lanes), 32'h0000_000f);
      end_of_test();
   end
endmodule : test_static_mem_strobe_timing
